// file: rtl/iwd_pkg.sv
package iwd_pkg;

  localparam logic [15:0] IDX_PORT = 16'h002E;
  localparam logic [15:0] DATA_PORT = 16'h002F;
  localparam logic [7:0] KEY_UNLOCK = 8'h87;
  localparam logic [7:0] KEY_LOCK = 8'hAA;
  localparam logic [7:0] REG_FUNC_SEL = 8'h07;
  localparam logic [7:0] REG_ACTIVATE = 8'h30;
  localparam logic [7:0] REG_UNIT = 8'hF5;
  localparam logic [7:0] REG_COUNT = 8'hF6;
  localparam logic [7:0] REG_CTRL = 8'hF7;
  localparam logic [7:0] FUNC_WDT = 8'h08;
  localparam logic [7:0] ACT_ON = 8'h01;
  localparam logic [7:0] READ_IDLE = 8'hFF;
  localparam int UNIT_MIN_BIT = 3;
  localparam int CTRL_MOUSE_BIT = 7;
  localparam int CTRL_KBD_BIT = 6;
  localparam int CTRL_FORCE_BIT = 5;
  localparam int CTRL_STATUS_BIT = 4;

  localparam int CLK_PERIOD_NS = 8;
  localparam int UNIT_SEC_NS = 1000000000;
  localparam int CYC_PER_SEC = UNIT_SEC_NS / CLK_PERIOD_NS;
  localparam int SECS_PER_MIN = 60;
  localparam int CYC_W = 27;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } iwd_io_req_t;

  typedef enum logic [1:0] {LK_LOCKED, LK_KEY1, LK_OPEN} iwd_lock_state_t;

  typedef struct packed {
    iwd_lock_state_t state;
  } iwd_lock_t;

  typedef struct packed {
    logic [CYC_W-1:0] cyc;
    logic [5:0] secs;
    logic sec_tick;
    logic min_tick;
  } iwd_tick_t;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] func_sel;
    logic active;
    logic unit_min;
    logic [7:0] reload;
    logic [7:0] count;
    logic kbd_en;
    logic mouse_en;
    logic timeout;
    logic [7:0] rdata;
    logic rvalid;
  } iwd_wdt_t;

  localparam iwd_lock_t LOCK_RST = '{state: LK_LOCKED};
  localparam iwd_tick_t TICK_RST = '{cyc: '0, secs: '0, sec_tick: 1'b0, min_tick: 1'b0};
  localparam iwd_wdt_t WDT_RST = '{index: 8'h00, func_sel: 8'h00, active: 1'b0,
    unit_min: 1'b0, reload: 8'h00, count: 8'h00, kbd_en: 1'b0, mouse_en: 1'b0,
    timeout: 1'b0, rdata: 8'h00, rvalid: 1'b0};

  function automatic logic iwd_port_hit(input logic [15:0] addr, input logic [15:0] port);
    iwd_port_hit = (addr == port);
  endfunction : iwd_port_hit

endpackage : iwd_pkg

// file: rtl/iwd_unit_tick.sv
`timescale 1ns/1ps
module iwd_unit_tick #(
  parameter int CYC_PER_SEC = iwd_pkg::CYC_PER_SEC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic restart_in,
  output logic sec_tick_out,
  output logic min_tick_out
);
  import iwd_pkg::*;

  iwd_tick_t st_reg;
  iwd_tick_t st_next;

  // Seconds and minutes are cut from the core clock; a restart realigns both.
  always_comb begin
    st_next = st_reg;
    st_next.sec_tick = 1'b0;
    st_next.min_tick = 1'b0;
    if (restart_in) begin
      st_next.cyc = '0;
      st_next.secs = '0;
    end else if (st_reg.cyc == CYC_W'(CYC_PER_SEC - 1)) begin
      st_next.cyc = '0;
      st_next.sec_tick = 1'b1;
      if (st_reg.secs == 6'(SECS_PER_MIN - 1)) begin
        st_next.secs = '0;
        st_next.min_tick = 1'b1;
      end else begin
        st_next.secs = st_reg.secs + 6'h01;
      end
    end else begin
      st_next.cyc = st_reg.cyc + CYC_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= TICK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sec_tick_out = st_reg.sec_tick;
  assign min_tick_out = st_reg.min_tick;

  a_min_needs_sec: assert property (@(posedge clk_in) disable iff (!resetn_in)
    min_tick_out |-> sec_tick_out)
    else $error("minute tick without second tick");

endmodule : iwd_unit_tick

// file: rtl/iwd_key_lock.sv
`timescale 1ns/1ps
module iwd_key_lock (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic idx_wr_in,
  input wire logic data_wr_in,
  input wire logic [7:0] wdata_in,
  output logic unlocked_out
);
  import iwd_pkg::*;

  iwd_lock_t st_reg;
  iwd_lock_t st_next;

  // Any port write between the two keys breaks the unlock sequence.
  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      LK_LOCKED: begin
        if (idx_wr_in && wdata_in == KEY_UNLOCK) begin
          st_next.state = LK_KEY1;
        end
      end
      LK_KEY1: begin
        if (idx_wr_in && wdata_in == KEY_UNLOCK) begin
          st_next.state = LK_OPEN;
        end else if (idx_wr_in || data_wr_in) begin
          st_next.state = LK_LOCKED;
        end
      end
      LK_OPEN: begin
        if (idx_wr_in && wdata_in == KEY_LOCK) begin
          st_next.state = LK_LOCKED;
        end
      end
      default: begin
        st_next.state = LK_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= LOCK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign unlocked_out = (st_reg.state == LK_OPEN);

  a_double_key_open: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(unlocked_out) |-> $past(idx_wr_in && wdata_in == KEY_UNLOCK)
      && $past(st_reg.state) == LK_KEY1)
    else $error("unlocked without two successive keys");

  a_lock_key_closes: assert property (@(posedge clk_in) disable iff (!resetn_in)
    unlocked_out && idx_wr_in && wdata_in == KEY_LOCK |=> !unlocked_out)
    else $error("lock key did not relock");

endmodule : iwd_key_lock

// file: rtl/iwd_watchdog.sv
`timescale 1ns/1ps
module iwd_watchdog #(
  parameter int CYC_PER_SEC = iwd_pkg::CYC_PER_SEC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input iwd_pkg::iwd_io_req_t io_req_in,
  input wire logic kbd_activity_in,
  input wire logic mouse_activity_in,
  output logic [7:0] io_rdata_out,
  output logic io_rvalid_out,
  output logic wdt_timeout_out
);
  import iwd_pkg::*;

  iwd_wdt_t st_reg;
  iwd_wdt_t st_next;
  logic idx_wr;
  logic data_wr;
  logic idx_rd;
  logic data_rd;
  logic unlocked;
  logic wdt_sel;
  logic sec_tick;
  logic min_tick;
  logic unit_tick;
  logic cnt_wr;
  logic ctrl_wr;
  logic force_to;
  logic key_restart;
  logic expire;
  logic restart;

  // Index and data ports are decoded from the host I/O address.
  assign idx_wr = io_req_in.wr && iwd_port_hit(io_req_in.addr, IDX_PORT);
  assign data_wr = io_req_in.wr && iwd_port_hit(io_req_in.addr, DATA_PORT);
  assign idx_rd = io_req_in.rd && iwd_port_hit(io_req_in.addr, IDX_PORT);
  assign data_rd = io_req_in.rd && iwd_port_hit(io_req_in.addr, DATA_PORT);

  iwd_key_lock u_key_lock (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .idx_wr_in(idx_wr),
    .data_wr_in(data_wr),
    .wdata_in(io_req_in.wdata),
    .unlocked_out(unlocked)
  );

  iwd_unit_tick #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_unit_tick (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .restart_in(restart),
    .sec_tick_out(sec_tick),
    .min_tick_out(min_tick)
  );

  // Watchdog registers are only reachable with the watchdog function selected.
  assign wdt_sel = unlocked && (st_reg.func_sel == FUNC_WDT);
  assign cnt_wr = data_wr && wdt_sel && (st_reg.index == REG_COUNT);
  assign ctrl_wr = data_wr && wdt_sel && (st_reg.index == REG_CTRL);
  assign force_to = ctrl_wr && io_req_in.wdata[CTRL_FORCE_BIT];
  assign unit_tick = st_reg.unit_min ? min_tick : sec_tick;
  assign key_restart = st_reg.active
    && ((st_reg.kbd_en && kbd_activity_in)
    || (st_reg.mouse_en && mouse_activity_in));
  assign expire = st_reg.active && (st_reg.count == 8'h01) && unit_tick;
  assign restart = cnt_wr || key_restart;

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    if (idx_wr && unlocked) begin
      st_next.index = io_req_in.wdata;
    end
    if (data_wr && unlocked && st_reg.index == REG_FUNC_SEL) begin
      st_next.func_sel = io_req_in.wdata;
    end
    if (data_wr && wdt_sel && st_reg.index == REG_ACTIVATE) begin
      st_next.active = (io_req_in.wdata == ACT_ON);
    end
    if (data_wr && wdt_sel && st_reg.index == REG_UNIT) begin
      st_next.unit_min = io_req_in.wdata[UNIT_MIN_BIT];
    end
    // Countdown; a zero count stays stopped.
    if (st_reg.active && st_reg.count != 8'h00 && unit_tick) begin
      st_next.count = st_reg.count - 8'h01;
    end
    if (key_restart) begin
      st_next.count = st_reg.reload;
    end
    if (cnt_wr) begin
      st_next.reload = io_req_in.wdata;
      st_next.count = io_req_in.wdata;
      st_next.timeout = 1'b0;
    end
    if (ctrl_wr) begin
      st_next.mouse_en = io_req_in.wdata[CTRL_MOUSE_BIT];
      st_next.kbd_en = io_req_in.wdata[CTRL_KBD_BIT];
      if (!io_req_in.wdata[CTRL_STATUS_BIT]) begin
        st_next.timeout = 1'b0;
      end
    end
    // Expiry and a forced timeout win over any clear in the same cycle.
    if (expire || force_to) begin
      st_next.timeout = 1'b1;
    end
    if (idx_rd || data_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = READ_IDLE;
      if (unlocked && idx_rd) begin
        st_next.rdata = st_reg.index;
      end else if (unlocked && st_reg.index == REG_FUNC_SEL) begin
        st_next.rdata = st_reg.func_sel;
      end else if (wdt_sel) begin
        case (st_reg.index)
          REG_ACTIVATE: begin
            st_next.rdata = {7'h00, st_reg.active};
          end
          REG_UNIT: begin
            st_next.rdata = 8'h00;
            st_next.rdata[UNIT_MIN_BIT] = st_reg.unit_min;
          end
          REG_COUNT: begin
            st_next.rdata = st_reg.count;
          end
          REG_CTRL: begin
            st_next.rdata = 8'h00;
            st_next.rdata[CTRL_MOUSE_BIT] = st_reg.mouse_en;
            st_next.rdata[CTRL_KBD_BIT] = st_reg.kbd_en;
            st_next.rdata[CTRL_STATUS_BIT] = st_reg.timeout;
          end
          default: begin
            st_next.rdata = READ_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= WDT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign io_rdata_out = st_reg.rdata;
  assign io_rvalid_out = st_reg.rvalid;
  assign wdt_timeout_out = st_reg.timeout;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_locked_write_ignored: assert property (
    data_wr && !unlocked |=> $stable(st_reg.reload) && $stable(st_reg.active)
      && $stable(st_reg.func_sel) && $stable(st_reg.kbd_en))
    else $error("data write took effect while locked");

  a_activate_value: assert property (
    data_wr && wdt_sel && st_reg.index == REG_ACTIVATE
      |=> st_reg.active == ($past(io_req_in.wdata) == ACT_ON))
    else $error("activation register not honoured");

  a_func_select_map: assert property (
    data_wr && unlocked && st_reg.index == REG_FUNC_SEL && io_req_in.wdata == FUNC_WDT
      ##1 unlocked |-> wdt_sel)
    else $error("watchdog set not mapped after select");

  a_index_decode: assert property (
    idx_wr && unlocked |=> st_reg.index == $past(io_req_in.wdata))
    else $error("index port write not latched");

  a_count_restart: assert property (
    cnt_wr |=> st_reg.count == $past(io_req_in.wdata)
      && st_reg.reload == $past(io_req_in.wdata))
    else $error("count write did not restart countdown");

  a_zero_holds: assert property (
    st_reg.count == 8'h00 && !cnt_wr && !key_restart |=> st_reg.count == 8'h00)
    else $error("zero count did not hold timer stopped");

  a_unit_decrement: assert property (
    st_reg.active && st_reg.count != 8'h00 && unit_tick && !cnt_wr && !key_restart
      |=> st_reg.count == $past(st_reg.count) - 8'h01)
    else $error("count did not drop on a unit tick");

  a_no_tick_holds: assert property (
    !unit_tick && !cnt_wr && !key_restart |=> $stable(st_reg.count))
    else $error("count moved without a unit tick");

  a_unit_minutes: assert property (
    st_reg.unit_min && sec_tick && !min_tick && !cnt_wr && !key_restart
      |=> $stable(st_reg.count))
    else $error("minute unit counted a second tick");

  a_expiry_timeout: assert property (
    expire |=> wdt_timeout_out ##1 wdt_timeout_out || $past(cnt_wr || ctrl_wr))
    else $error("expiry did not raise timeout");

  a_force_timeout: assert property (
    force_to |=> wdt_timeout_out)
    else $error("forced timeout not raised");

  a_ctrl_readback: assert property (
    data_rd && wdt_sel && st_reg.index == REG_CTRL
      |=> io_rvalid_out && !io_rdata_out[CTRL_FORCE_BIT]
      && io_rdata_out[CTRL_STATUS_BIT] == $past(st_reg.timeout))
    else $error("control readback wrong");

  a_kbd_restart: assert property (
    key_restart && kbd_activity_in && !cnt_wr |=> st_reg.count == $past(st_reg.reload))
    else $error("keyboard activity did not restart");

  a_mouse_restart: assert property (
    key_restart && mouse_activity_in && !cnt_wr
      |=> st_reg.count == $past(st_reg.reload))
    else $error("mouse activity did not restart");

  a_kbd_gated: assert property (
    !st_reg.kbd_en && !st_reg.mouse_en |-> !key_restart)
    else $error("restart without enable bit");

  a_read_answer: assert property (
    idx_rd || data_rd |=> io_rvalid_out)
    else $error("read not answered in the next cycle");

  a_rvalid_pulse: assert property (
    !idx_rd && !data_rd |=> !io_rvalid_out)
    else $error("read valid without a read");

  a_rdata_holds: assert property (
    !idx_rd && !data_rd |=> $stable(io_rdata_out))
    else $error("read data changed without a read");

  a_locked_read_idle: assert property (
    (idx_rd || data_rd) && !unlocked |=> io_rdata_out == READ_IDLE)
    else $error("locked read did not return idle value");

  a_unmapped_read_idle: assert property (
    data_rd && unlocked && !wdt_sel && st_reg.index != REG_FUNC_SEL
      |=> io_rdata_out == READ_IDLE)
    else $error("unmapped read did not return idle value");

  a_unmapped_write_ignored: assert property (
    data_wr && unlocked && !wdt_sel |=> $stable(st_reg.active) && $stable(st_reg.reload)
      && $stable(st_reg.unit_min) && $stable(st_reg.kbd_en))
    else $error("write took effect without watchdog selected");

  a_locked_index_hold: assert property (
    idx_wr && !unlocked |=> $stable(st_reg.index))
    else $error("index latched while locked");

  a_unit_select: assert property (
    data_wr && wdt_sel && st_reg.index == REG_UNIT
      |=> st_reg.unit_min == $past(io_req_in.wdata[UNIT_MIN_BIT]))
    else $error("unit bit not taken");

  a_ctrl_enables: assert property (
    ctrl_wr |=> st_reg.kbd_en == $past(io_req_in.wdata[CTRL_KBD_BIT])
      && st_reg.mouse_en == $past(io_req_in.wdata[CTRL_MOUSE_BIT]))
    else $error("activity enable bits not taken");

  a_inactive_holds: assert property (
    !st_reg.active && !cnt_wr |=> $stable(st_reg.count))
    else $error("count moved while watchdog inactive");

  a_timeout_sticky: assert property (
    wdt_timeout_out && !cnt_wr && !ctrl_wr |=> wdt_timeout_out)
    else $error("timeout status dropped without a clear");

  a_timeout_source: assert property (
    $rose(wdt_timeout_out) |-> $past(expire || force_to))
    else $error("timeout rose without expiry or force");

  a_expire_empties: assert property (
    expire && !cnt_wr && !key_restart |=> st_reg.count == 8'h00)
    else $error("count not zero after expiry");

  a_zero_no_timeout: assert property (
    st_reg.count == 8'h00 && !wdt_timeout_out && !force_to
      |=> !wdt_timeout_out)
    else $error("stopped timer raised timeout");

  a_ctrl_clear_status: assert property (
    ctrl_wr && !io_req_in.wdata[CTRL_STATUS_BIT] && !expire && !force_to
      |=> !wdt_timeout_out)
    else $error("status clear not honoured");

  a_count_clears_timeout: assert property (
    cnt_wr && !expire |=> !wdt_timeout_out)
    else $error("count write did not clear timeout");

  a_func_sel_write: assert property (
    data_wr && unlocked && st_reg.index == REG_FUNC_SEL
      |=> st_reg.func_sel == $past(io_req_in.wdata))
    else $error("function select write not taken");

  a_func_sel_read: assert property (
    data_rd && unlocked && st_reg.index == REG_FUNC_SEL
      |=> io_rdata_out == $past(st_reg.func_sel))
    else $error("function select readback wrong");

  a_index_read: assert property (
    idx_rd && unlocked |=> io_rdata_out == $past(st_reg.index))
    else $error("index readback wrong");

  a_count_read: assert property (
    data_rd && wdt_sel && st_reg.index == REG_COUNT
      |=> io_rdata_out == $past(st_reg.count))
    else $error("count readback wrong");

  a_activate_read: assert property (
    data_rd && wdt_sel && st_reg.index == REG_ACTIVATE
      |=> io_rdata_out == {7'h00, $past(st_reg.active)})
    else $error("activation readback wrong");

  a_unit_read: assert property (
    data_rd && wdt_sel && st_reg.index == REG_UNIT
      |=> io_rdata_out[UNIT_MIN_BIT] == $past(st_reg.unit_min))
    else $error("unit readback wrong");

  a_restart_realign: assert property (
    restart |=> !sec_tick && !min_tick)
    else $error("unit tick right after a restart");

  a_sec_tick_pulse: assert property (
    sec_tick |=> !sec_tick)
    else $error("second tick longer than one cycle");

  a_minute_pulse: assert property (
    min_tick |=> !min_tick)
    else $error("minute tick longer than one cycle");

  a_force_needs_map: assert property (
    data_wr && !wdt_sel && !expire |=> !$rose(wdt_timeout_out))
    else $error("timeout forced without watchdog selected");

  a_seconds_count: assert property (
    !st_reg.unit_min && st_reg.active && sec_tick && st_reg.count != 8'h00 && !cnt_wr
      && !key_restart |=> st_reg.count == $past(st_reg.count) - 8'h01)
    else $error("second unit did not count a second tick");

  a_unit_min_idle: assert property (
    st_reg.unit_min && !min_tick && !cnt_wr && !key_restart
      |=> $stable(st_reg.count))
    else $error("minute unit counted between minute ticks");

endmodule : iwd_watchdog

// file: bench/indexed_port_watchdog_timer_tb.sv
`timescale 1ns/1ps
module indexed_port_watchdog_timer_tb;
  import iwd_pkg::*;

  // Short unit so that second and minute intervals fit a short run.
  localparam int CPS = 10;

  logic clk_in;
  logic resetn_in;
  iwd_io_req_t io_req;
  logic kbd_act;
  logic mouse_act;
  logic [7:0] io_rdata;
  logic io_rvalid;
  logic wdt_timeout;
  logic [7:0] d;
  int num_errors = 0;
  int checks = 0;

  iwd_watchdog #(.CYC_PER_SEC(CPS)) uut (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .io_req_in(io_req),
    .kbd_activity_in(kbd_act),
    .mouse_activity_in(mouse_act),
    .io_rdata_out(io_rdata),
    .io_rvalid_out(io_rvalid),
    .wdt_timeout_out(wdt_timeout)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    io_req <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(posedge clk_in);
    io_req <= '{addr: addr, wr: 1'b0, rd: 1'b0, wdata: data};
  endtask : io_write

  task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clk_in);
    io_req <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_in);
    io_req <= '{addr: addr, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    #1;
    chk({31'h0, io_rvalid}, 32'h1);
    data = io_rdata;
  endtask : io_read

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    io_write(IDX_PORT, idx);
    io_write(DATA_PORT, val);
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    io_write(IDX_PORT, idx);
    io_read(DATA_PORT, got);
    chk({24'h0, got}, {24'h0, exp});
  endtask : reg_chk

  task automatic unlock;
    io_write(IDX_PORT, KEY_UNLOCK);
    io_write(IDX_PORT, KEY_UNLOCK);
  endtask : unlock

  // Counts cycles until the timeout output rises and checks the span.
  task automatic measure(input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (wdt_timeout !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
  endtask : measure

  task automatic quiet(input int cyc);
    repeat (cyc) @(posedge clk_in);
    #1;
    chk({31'h0, wdt_timeout}, 32'h0);
  endtask : quiet

  initial begin
    #(8 * 20000);
    num_errors++;
    final_report();
  end

  initial begin
    resetn_in = 1'b0;
    io_req = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    kbd_act = 1'b0;
    mouse_act = 1'b0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    quiet(1);
    io_read(DATA_PORT, d);
    chk({24'h0, d}, 32'hFF);
    io_write(IDX_PORT, KEY_UNLOCK);
    io_write(IDX_PORT, REG_FUNC_SEL);
    io_write(DATA_PORT, FUNC_WDT);
    unlock();
    io_write(16'h012E, KEY_LOCK);
    reg_chk(REG_FUNC_SEL, 8'h00);
    io_read(IDX_PORT, d);
    chk({24'h0, d}, {24'h0, REG_FUNC_SEL});
    reg_wr(REG_FUNC_SEL, FUNC_WDT);
    reg_chk(REG_FUNC_SEL, 8'h08);
    reg_chk(REG_ACTIVATE, 8'h00);
    reg_chk(REG_UNIT, 8'h00);
    reg_chk(REG_COUNT, 8'h00);
    reg_chk(REG_CTRL, 8'h00);
    reg_wr(REG_ACTIVATE, ACT_ON);
    reg_chk(REG_ACTIVATE, 8'h01);
    reg_wr(REG_COUNT, 8'h03);
    measure(3 * CPS - 1, 3 * CPS + 4);
    reg_chk(REG_CTRL, 8'h10);
    reg_wr(REG_COUNT, 8'h02);
    quiet(CPS);
    reg_chk(REG_COUNT, 8'h01);
    reg_wr(REG_COUNT, 8'h02);
    measure(2 * CPS - 1, 2 * CPS + 4);
    reg_wr(REG_COUNT, 8'hFF);
    measure(255 * CPS - 1, 255 * CPS + 4);
    reg_wr(REG_UNIT, 8'h08);
    reg_chk(REG_UNIT, 8'h08);
    reg_wr(REG_COUNT, 8'h01);
    measure(60 * CPS - 1, 60 * CPS + 4);
    reg_wr(REG_UNIT, 8'h00);
    for (int i = 0; i < 2; i++) begin
      reg_wr(REG_CTRL, i ? 8'h80 : 8'h40);
      reg_chk(REG_CTRL, i ? 8'h80 : 8'h40);
      reg_wr(REG_COUNT, 8'h02);
      repeat (CPS + CPS / 2) @(posedge clk_in);
      if (i) begin
        mouse_act <= 1'b1;
      end else begin
        kbd_act <= 1'b1;
      end
      @(posedge clk_in);
      kbd_act <= 1'b0;
      mouse_act <= 1'b0;
      measure(2 * CPS - 1, 2 * CPS + 4);
      reg_chk(REG_CTRL, (i ? 8'h80 : 8'h40) | 8'h10);
    end
    reg_wr(REG_COUNT, 8'h00);
    quiet(1);
    reg_wr(REG_CTRL, 8'h20);
    @(posedge clk_in);
    #1;
    chk({31'h0, wdt_timeout}, 32'h1);
    reg_chk(REG_CTRL, 8'h10);
    reg_wr(REG_CTRL, 8'h00);
    quiet(3 * CPS);
    io_write(IDX_PORT, KEY_LOCK);
    reg_wr(REG_COUNT, 8'h01);
    quiet(2 * CPS + 5);
    io_read(DATA_PORT, d);
    chk({24'h0, d}, 32'hFF);
    unlock();
    reg_wr(REG_ACTIVATE, 8'h00);
    reg_wr(REG_COUNT, 8'h01);
    quiet(2 * CPS + 5);
    final_report();
  end

endmodule : indexed_port_watchdog_timer_tb
